/* hdl/lsd_dummy_unused.sv */
// Spare source slot of the driver; holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* hdl/lsd_pkg.sv */
// Shared constants and types of the segment LCD driver control block
package lsd_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [6:0] LSD_IDX_CLOCK = 7'h4f;
  localparam logic [6:0] LSD_IDX_CONTROL = 7'h51;
  localparam logic [6:0] LSD_IDX_SEG_FIRST = 7'h52;
  localparam logic [6:0] LSD_IDX_SEG_LAST = 7'h5f;
  localparam int LSD_SEG_REGS = 14;
  localparam int LSD_FRONTPLANES = 27;
  localparam int LSD_BACKPLANES = 4;

  // Control register fields
  localparam int LSD_CR_EN_BIT = 7;
  localparam int LSD_CR_QUICK_BIT = 5;
  localparam int LSD_CR_DRAIN_BIT = 4;
  localparam int LSD_CR_CON_LSB = 0;
  localparam logic [7:0] LSD_CR_RESET = 8'h00;

  // Clock register fields
  localparam int LSD_CK_FCD_LSB = 5;
  localparam int LSD_CK_DUTY_LSB = 3;
  localparam int LSD_CK_SEL_LSB = 0;
  localparam logic [7:0] LSD_CK_RESET = 8'h00;

  // Last segment register has only its low nibble implemented
  localparam logic [7:0] LSD_SEG_LAST_MASK = 8'h0f;

  // Duty codes
  localparam logic [1:0] LSD_DUTY_STATIC = 2'h0;
  localparam logic [1:0] LSD_DUTY_THIRD = 2'h1;
  localparam logic [1:0] LSD_DUTY_QUARTER = 2'h2;
  localparam logic [1:0] LSD_DUTY_UNUSED = 2'h3;
  localparam logic [1:0] LSD_LAST_PHASE_THIRD = 2'h2;
  localparam logic [1:0] LSD_LAST_PHASE_QUARTER = 2'h3;

  // Fast-charge duration codes
  localparam logic [1:0] LSD_FCD_UNUSED = 2'h3;
  localparam int LSD_FCD_SHIFT_32 = 5;
  localparam int LSD_FCD_SHIFT_64 = 6;
  localparam int LSD_FCD_SHIFT_128 = 7;

  // Base clock divide ratios by select code; code 7 is reserved
  localparam logic [2:0] LSD_SEL_RESERVED = 3'h7;
  localparam logic [6:0][16:0] LSD_DIV_RATIO = {
    17'h10000, 17'h08000, 17'h04000, 17'h00400,
    17'h00200, 17'h00100, 17'h00080};

  // Pin drive levels, counted in thirds below the supply
  localparam logic [1:0] LSD_LVL_SUPPLY = 2'h0;
  localparam logic [1:0] LSD_LVL_TWO_THIRDS = 2'h1;
  localparam logic [1:0] LSD_LVL_ONE_THIRD = 2'h2;
  localparam logic [1:0] LSD_LVL_BIAS = 2'h3;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN} lsd_seq_e;

endpackage

/* hdl/lsd_plane_levels.sv */
// Backplane and frontplane drive level selection for one phase
`timescale 1ns/1ps
`default_nettype none

module lsd_plane_levels (
  // Sequencer state
  input wire logic active,
  input wire logic staticMode,
  input wire logic [1:0] phase,
  input wire logic halfB,
  // Segment bits, four per frontplane
  input wire logic [26:0][3:0] segBits,
  // Levels
  output logic [3:0][1:0] bpLevel,
  output logic [26:0][1:0] fpLevel
);

  genvar b;
  genvar f;

  generate
    for (b = 0; b < lsd_pkg::LSD_BACKPLANES; b = b + 1)
    begin : gBp
      logic selected;
      assign selected = staticMode || (phase == 2'(b));
      always_comb
      begin
        if (!active)
        begin
          bpLevel[b] = lsd_pkg::LSD_LVL_SUPPLY; // RQ13
        end
        else if (selected)
        begin
          bpLevel[b] = halfB ? lsd_pkg::LSD_LVL_BIAS :
            lsd_pkg::LSD_LVL_SUPPLY; // RQ14
        end
        else
        begin
          bpLevel[b] = halfB ? lsd_pkg::LSD_LVL_TWO_THIRDS :
            lsd_pkg::LSD_LVL_ONE_THIRD;
        end
      end
    end

    for (f = 0; f < lsd_pkg::LSD_FRONTPLANES; f = f + 1)
    begin : gFp
      logic segOn;
      assign segOn = staticMode ? segBits[f][0] : segBits[f][phase];
      always_comb
      begin
        if (!active)
        begin
          fpLevel[f] = lsd_pkg::LSD_LVL_SUPPLY; // RQ13
        end
        else if (segOn)
        begin
          // Opposite of the selected backplane: full voltage across
          fpLevel[f] = halfB ? lsd_pkg::LSD_LVL_SUPPLY :
            lsd_pkg::LSD_LVL_BIAS; // RQ12
        end
        else if (staticMode)
        begin
          fpLevel[f] = halfB ? lsd_pkg::LSD_LVL_BIAS :
            lsd_pkg::LSD_LVL_SUPPLY;
        end
        else
        begin
          // One third across against either backplane state
          fpLevel[f] = halfB ? lsd_pkg::LSD_LVL_ONE_THIRD :
            lsd_pkg::LSD_LVL_TWO_THIRDS;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* hdl/lsd_prescaler.sv */
// Base clock divider and fast-charge window generator
`timescale 1ns/1ps
`default_nettype none

module lsd_prescaler (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control
  input wire logic refTick,
  input wire logic restart,
  input wire logic [2:0] baseSel,
  input wire logic [1:0] chargeDur,
  // Timing
  output logic halfB,
  output logic periodEnd,
  output logic fastWindow
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0] prevSel;
  } lsd_pre_s;

  lsd_pre_s s_reg;
  lsd_pre_s s_next;
  logic [16:0] ratio;
  logic [16:0] halfBit;
  logic [16:0] halfPos;
  logic [16:0] fastLen;
  logic [15:0] divMax;

  always_comb
  begin
    ratio = lsd_pkg::LSD_DIV_RATIO[baseSel];
    if (baseSel == lsd_pkg::LSD_SEL_RESERVED)
    begin
      ratio = lsd_pkg::LSD_DIV_RATIO[0];
    end
    halfBit = ratio >> 1;
    divMax = 16'(ratio - 17'h00001);
    halfPos = {1'b0, s_reg.cnt} & (halfBit - 17'h00001);
    case (chargeDur)
      2'h0: fastLen = ratio >> lsd_pkg::LSD_FCD_SHIFT_32;
      2'h1: fastLen = ratio >> lsd_pkg::LSD_FCD_SHIFT_64;
      2'h2: fastLen = ratio >> lsd_pkg::LSD_FCD_SHIFT_128;
      default: fastLen = 17'h00000;
    endcase
    halfB = ({1'b0, s_reg.cnt} & halfBit) != 17'h00000; // RQ9
    // Window opens at the start of each half period
    fastWindow = halfPos < fastLen; // RQ5
    periodEnd = refTick && (s_reg.cnt == divMax) && !restart;
    s_next = s_reg;
    s_next.prevSel = baseSel;
    if (restart || (baseSel != s_reg.prevSel))
    begin
      s_next.cnt = 16'h0000;
    end
    else if (refTick)
    begin
      if (s_reg.cnt == divMax)
      begin
        s_next.cnt = 16'h0000; // RQ10
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

`default_nettype wire

/* hdl/lsd_segment_driver.sv */
// Segment LCD driver control: registers, sequencer and pin levels
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1 - Enable bit drives waveforms; reset clears it
// RQ2 - Low-current and fast-charge pick ladder resistance
// RQ3 - Reset clears both ladder bits: high current
// RQ4 - Four-bit contrast code, zero is maximum
// RQ5 - Fast charge holds low resistance each half
// RQ6 - Duration field read/write, resets to 1/32
// RQ7 - Duty field picks static, third, quarter, shared pin
// RQ8 - Duty resets to static, shared pin frontplane
// RQ9 - Base clock divides reference by 128 to 1024
// RQ10 - Codes 4 to 6 divide by 16K-64K
// RQ11 - Sixteen registers: control, clock, fourteen segment
// RQ12 - Segment bit one lights, zero darkens segment
// RQ13 - Disabled: all pins at supply, ladder off
// RQ14 - Frame is base period times phase count
// RQ15 - One phase per period, restart on change
// RQ16 - Unused codes give safe idle outputs; the unused duration code 3 only disables fast charge, the panel keeps running
module lsd_segment_driver (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reference crystal clock, asynchronous to clock
  input wire logic reference_crystal_clock,
  // Panel drive levels, counted in thirds below the supply
  output logic [2:0][1:0] backplane_outputs,
  output logic [25:0][1:0] frontplane_outputs,
  output logic [1:0] shared_plane_pin,
  output logic sharedIsBackplane,
  // Analog ladder control
  output logic ladderConnect,
  output logic ladderHighCurrent,
  output logic [3:0] contrast_code,
  // Waveform base clock
  output logic waveform_base_clock
);

  typedef struct packed {
    logic driver_enable;
    logic quick_charge_select;
    logic low_drain_select;
    logic [3:0] contrast;
    logic [1:0] quick_charge_duration;
    logic [1:0] duty;
    logic [2:0] base_clock_divider_select;
    logic [13:0][7:0] segment_data_regs;
    logic wrPend;
    logic wrHit;
    logic [6:0] wrIdx;
    logic [7:0] rdata;
    logic [2:0] refSync;
    lsd_pkg::lsd_seq_e seq;
    logic [1:0] phase;
    logic [1:0] prevDuty;
    logic prevEn;
    logic [2:0][1:0] bpLvl;
    logic [25:0][1:0] fpLvl;
    logic [1:0] sharedLvl;
    logic sharedBp;
    logic ladderOn;
    logic ladderHigh;
    logic baseClk;
  } lsd_main_s;

  lsd_main_s s_reg;
  lsd_main_s s_next;

  logic addrPhase;
  logic active;
  logic restart;
  logic refTick;
  logic halfB;
  logic periodEnd;
  logic fastWindow;
  logic staticMode;
  logic [1:0] lastPhase;
  logic [3:0][1:0] bpLevel;
  logic [26:0][1:0] fpLevel;
  logic [26:0][3:0] segBits;

  // Read value of one register index; unmapped words read zero
  function automatic logic [7:0] readReg(input lsd_main_s st,
                                          input logic hit,
                                          input logic [6:0] idx);
    logic [7:0] v;
    logic [6:0] segIdx;
    v = 8'h00;
    segIdx = idx - lsd_pkg::LSD_IDX_SEG_FIRST;
    if (hit)
    begin
      if (idx == lsd_pkg::LSD_IDX_CONTROL)
      begin
        v[lsd_pkg::LSD_CR_EN_BIT] = st.driver_enable;
        v[lsd_pkg::LSD_CR_QUICK_BIT] = st.quick_charge_select;
        v[lsd_pkg::LSD_CR_DRAIN_BIT] = st.low_drain_select;
        v[lsd_pkg::LSD_CR_CON_LSB +: 4] = st.contrast;
      end
      else if (idx == lsd_pkg::LSD_IDX_CLOCK)
      begin
        v[lsd_pkg::LSD_CK_FCD_LSB +: 2] = st.quick_charge_duration;
        v[lsd_pkg::LSD_CK_DUTY_LSB +: 2] = st.duty;
        v[lsd_pkg::LSD_CK_SEL_LSB +: 3] = st.base_clock_divider_select;
      end
      else if (idx >= lsd_pkg::LSD_IDX_SEG_FIRST &&
               idx <= lsd_pkg::LSD_IDX_SEG_LAST)
      begin
        v = st.segment_data_regs[segIdx[3:0]];
      end
    end
    return v;
  endfunction

  // Reference clock enters through a two-stage synchroniser
  assign refTick = s_reg.refSync[1] && !s_reg.refSync[2];

  // Reserved duty or base clock codes hold the panel in its off state
  assign active = s_reg.driver_enable &&
    (s_reg.duty != lsd_pkg::LSD_DUTY_UNUSED) &&
    (s_reg.base_clock_divider_select != lsd_pkg::LSD_SEL_RESERVED); // RQ16
  assign restart = !active || (s_reg.duty != s_reg.prevDuty) ||
    (s_reg.driver_enable != s_reg.prevEn); // RQ15
  assign staticMode = s_reg.duty == lsd_pkg::LSD_DUTY_STATIC; // RQ7
  assign lastPhase = (s_reg.duty == lsd_pkg::LSD_DUTY_QUARTER) ?
    lsd_pkg::LSD_LAST_PHASE_QUARTER : lsd_pkg::LSD_LAST_PHASE_THIRD;
  // Upper nibble of the last register has no frontplane behind it
  assign segBits = 108'(s_reg.segment_data_regs);

  assign addrPhase = hsel && hready && htrans[1];

  lsd_prescaler uPrescaler (
    .clock(clock),
    .sys_rst(sys_rst),
    .refTick(refTick),
    .restart(restart),
    .baseSel(s_reg.base_clock_divider_select),
    .chargeDur(s_reg.quick_charge_duration),
    .halfB(halfB),
    .periodEnd(periodEnd),
    .fastWindow(fastWindow)
  );

  lsd_plane_levels uLevels (
    .active(active),
    .staticMode(staticMode),
    .phase(s_reg.phase),
    .halfB(halfB),
    .segBits(segBits),
    .bpLevel(bpLevel),
    .fpLevel(fpLevel)
  );

  always_comb
  begin
    s_next = s_reg;
    s_next.refSync = {s_reg.refSync[1:0], reference_crystal_clock};
    s_next.prevDuty = s_reg.duty;
    s_next.prevEn = s_reg.driver_enable;

    // Data phase of a write lands here, one cycle after its address
    if (s_reg.wrPend && s_reg.wrHit)
    begin
      if (s_reg.wrIdx == lsd_pkg::LSD_IDX_CONTROL)
      begin
        s_next.driver_enable = hwdata[lsd_pkg::LSD_CR_EN_BIT]; // RQ1
        s_next.quick_charge_select = hwdata[lsd_pkg::LSD_CR_QUICK_BIT];
        s_next.low_drain_select = hwdata[lsd_pkg::LSD_CR_DRAIN_BIT];
        s_next.contrast = hwdata[lsd_pkg::LSD_CR_CON_LSB +: 4]; // RQ4
      end
      else if (s_reg.wrIdx == lsd_pkg::LSD_IDX_CLOCK)
      begin
        s_next.quick_charge_duration =
          hwdata[lsd_pkg::LSD_CK_FCD_LSB +: 2]; // RQ6
        s_next.duty = hwdata[lsd_pkg::LSD_CK_DUTY_LSB +: 2]; // RQ8
        s_next.base_clock_divider_select =
          hwdata[lsd_pkg::LSD_CK_SEL_LSB +: 3]; // RQ9
      end
      else if (s_reg.wrIdx >= lsd_pkg::LSD_IDX_SEG_FIRST &&
               s_reg.wrIdx <= lsd_pkg::LSD_IDX_SEG_LAST)
      begin
        if (s_reg.wrIdx == lsd_pkg::LSD_IDX_SEG_LAST)
        begin
          s_next.segment_data_regs[lsd_pkg::LSD_SEG_REGS - 1] =
            hwdata[7:0] & lsd_pkg::LSD_SEG_LAST_MASK;
        end
        else
        begin
          s_next.segment_data_regs[4'(s_reg.wrIdx -
            lsd_pkg::LSD_IDX_SEG_FIRST)] = hwdata[7:0]; // RQ11
        end
      end
    end

    s_next.wrPend = addrPhase && hwrite;
    if (addrPhase)
    begin
      s_next.wrHit = haddr[31:9] == 23'h000000;
      s_next.wrIdx = haddr[8:2];
      if (!hwrite)
      begin
        // Reading the updated copy forwards a write just completed
        s_next.rdata = readReg(s_next, haddr[31:9] == 23'h000000,
                               haddr[8:2]); // RQ11
      end
    end

    // Phase sequencer
    case (s_reg.seq)
      lsd_pkg::SEQ_IDLE:
      begin
        s_next.phase = 2'h0;
        if (active)
        begin
          s_next.seq = lsd_pkg::SEQ_RUN;
        end
      end
      lsd_pkg::SEQ_RUN:
      begin
        if (restart)
        begin
          s_next.phase = 2'h0; // RQ15
          s_next.seq = active ? lsd_pkg::SEQ_RUN : lsd_pkg::SEQ_IDLE;
        end
        else if (periodEnd)
        begin
          if (staticMode || s_reg.phase == lastPhase)
          begin
            s_next.phase = 2'h0; // RQ14
          end
          else
          begin
            s_next.phase = s_reg.phase + 2'h1;
          end
        end
      end
      default:
      begin
        s_next.seq = lsd_pkg::SEQ_IDLE;
        s_next.phase = 2'h0;
      end
    endcase

    // Registered pin levels; shared pin follows the duty selection
    s_next.bpLvl = bpLevel[2:0];
    s_next.fpLvl = fpLevel[26:1];
    s_next.sharedBp = s_reg.duty == lsd_pkg::LSD_DUTY_QUARTER; // RQ7
    s_next.sharedLvl = s_next.sharedBp ? bpLevel[3] : fpLevel[0];

    // 37k is the low resistance; fast charge pulses it in over 146k
    s_next.ladderOn = active; // RQ13
    s_next.ladderHigh = !s_reg.low_drain_select ||
      (s_reg.quick_charge_select && fastWindow); // RQ2
    s_next.baseClk = active && !halfB;
  end

  // Reset leaves everything zero: driver off, ladder at high current
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_reg <= '0; // RQ3
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign hrdata = {24'h000000, s_reg.rdata};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign backplane_outputs = s_reg.bpLvl;
  assign frontplane_outputs = s_reg.fpLvl;
  assign shared_plane_pin = s_reg.sharedLvl;
  assign sharedIsBackplane = s_reg.sharedBp;
  assign ladderConnect = s_reg.ladderOn;
  assign ladderHighCurrent = s_reg.ladderHigh && s_reg.ladderOn;
  assign contrast_code = s_reg.contrast;
  assign waveform_base_clock = s_reg.baseClk;

endmodule

`default_nettype wire

/* sim/lsd_panel_model.sv */
// Passive segment glass: frame length and one lit segment on backplane 0
`timescale 1ns/1ps
`default_nettype none
module lsd_panel_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Panel lines
  input wire logic [1:0] backLine,
  input wire logic [1:0] frontLine,
  // Observations
  output logic [15:0] frameLen,
  output logic litSeen
);
  logic [1:0] prevBack;
  logic [15:0] cnt;
  logic lit, entry, full;
  // Glass only loads the lines; it never drives anything back
  assign entry = backLine == 2'h0 && prevBack != 2'h0;
  assign full = (backLine == 2'h0 && frontLine == 2'h3)
    || (backLine == 2'h3 && frontLine == 2'h0);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      prevBack <= 2'h0;
      cnt <= 16'h0;
      frameLen <= 16'h0;
      lit <= 1'b0;
      litSeen <= 1'b0;
    end
    else
    begin
      prevBack <= backLine;
      cnt <= entry ? 16'h0 : cnt + 16'h1;
      lit <= (entry ? 1'b0 : lit) | full;
      if (entry)
      begin
        frameLen <= cnt + 16'h1;
        litSeen <= lit;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/lsd_segment_driver_props.sv */
// Port checker of the segment LCD driver control block
`timescale 1ns/1ps
`default_nettype none
module lsd_segment_driver_props (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Panel and ladder
  input wire logic reference_crystal_clock,
  input wire logic [2:0][1:0] backplane_outputs,
  input wire logic [25:0][1:0] frontplane_outputs,
  input wire logic [1:0] shared_plane_pin,
  input wire logic sharedIsBackplane,
  input wire logic ladderConnect,
  input wire logic ladderHighCurrent,
  input wire logic [3:0] contrast_code,
  input wire logic waveform_base_clock
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic wrPend, hitC, hitK, rdTake;
  logic [6:0] wrIdx;
  logic [7:0] ctlQ, ckQ;
  logic [1:0] age;
  assign rdTake = hsel && hready && htrans[1] && !hwrite;
  assign hitC = wrPend && wrIdx == lsd_pkg::LSD_IDX_CONTROL;
  assign hitK = wrPend && wrIdx == lsd_pkg::LSD_IDX_CLOCK;
  // Shadow registers; checks that read them, except a_enable_drive, wait until a write has settled
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPend <= 1'b0;
      wrIdx <= 7'h00;
      ctlQ <= 8'h00;
      ckQ <= 8'h00;
      age <= 2'h3;
    end
    else
    begin
      wrPend <= hsel && hready && htrans[1] && hwrite;
      wrIdx <= haddr[8:2];
      if (hitC)
        ctlQ <= hwdata[7:0];
      if (hitK)
        ckQ <= hwdata[7:0];
      if (hitC || hitK)
        age <= 2'h0;
      else if (age != 2'h3)
        age <= age + 2'h1;
    end
  end
  sequence sEnWrite;
    hitC && hwdata[7] && ckQ[4:3] != 2'h3 && ckQ[2:0] != 3'h7;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_read_hold: assert property (!$past(rdTake) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_enable_drive: assert property (sEnWrite |-> ##[1:3] ladderConnect)
    else $error("enable did not start the driver");
  a_off_quiet: assert property (!ladderConnect [*3] |->
    backplane_outputs == '0 && frontplane_outputs == '0
    && shared_plane_pin == 2'h0 && !waveform_base_clock)
    else $error("pins not at supply while off");
  a_current_needs_ladder: assert property (ladderHighCurrent
    |-> ladderConnect || $past(ladderConnect))
    else $error("ladder current while disconnected");
  a_shared_role: assert property (age == 2'h3
    |-> sharedIsBackplane == (ckQ[4:3] == 2'h2))
    else $error("shared pin role wrong");
  a_contrast_follow: assert property (age == 2'h3
    |-> contrast_code == ctlQ[3:0])
    else $error("contrast code wrong");
  a_high_default: assert property (age == 2'h3 && ladderConnect
    && !ctlQ[4] |-> ladderHighCurrent)
    else $error("high current not selected");
  a_low_current: assert property (age == 2'h3 && ladderConnect
    && ctlQ[5:4] == 2'h1 |-> !ladderHighCurrent)
    else $error("low current not selected");
  a_reserved_safe: assert property (age == 2'h3 && (ckQ[4:3] == 2'h3
    || ckQ[2:0] == 3'h7) |-> !ladderConnect)
    else $error("reserved code drives the panel");
  a_base_active: assert property ($rose(waveform_base_clock)
    |-> ladderConnect)
    else $error("base clock while inactive");
endmodule
`default_nettype wire

/* sim/tb.sv */
// Testbench of the segment LCD driver control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, sys_rst, hsel, hwrite, refClk, hreadyout, hresp, hready;
  logic sharedIsBackplane, ladderConnect, ladderHighCurrent, wbc, litSeen;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, shp;
  logic [2:0] hsize;
  logic [2:0][1:0] bp;
  logic [25:0][1:0] fp;
  logic [3:0] con;
  logic [15:0] frameLen;
  logic [7:0] lt [4] = '{8'h80, 8'ha0, 8'h90, 8'hb0};
  int miscompares, n_tests;
  localparam logic [6:0] C = lsd_pkg::LSD_IDX_CONTROL;
  localparam logic [6:0] K = lsd_pkg::LSD_IDX_CLOCK;
  localparam logic [6:0] S = lsd_pkg::LSD_IDX_SEG_FIRST;
  assign hready = hreadyout;
  lsd_segment_driver u_dut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .reference_crystal_clock(refClk), .backplane_outputs(bp),
    .frontplane_outputs(fp), .shared_plane_pin(shp),
    .sharedIsBackplane(sharedIsBackplane), .ladderConnect(ladderConnect),
    .ladderHighCurrent(ladderHighCurrent), .contrast_code(con),
    .waveform_base_clock(wbc));
  lsd_panel_model u_panel (.clock(clock), .sys_rst(sys_rst),
    .backLine(bp[0]), .frontLine(fp[0]), .frameLen(frameLen),
    .litSeen(litSeen));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Reference runs at a quarter of the system rate, phase unrelated
  initial
  begin
    refClk = 1'b0;
    #7;
    forever #50 refClk = ~refClk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hready !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] idx,
    input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {23'h0, idx, 2'h0};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata;
  endtask
  task automatic rd_check(input string nm, input logic [6:0] idx,
    input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check(nm, q, {24'h0, e});
  endtask
  task automatic wait_lvl(input logic v, inout int n);
    while (wbc !== v && n < 9000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 9000)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask
  initial
  begin
    int p, c, ph;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rd_check("control reset", C, 8'h00);
    rd_check("clock reset", K, 8'h00);
    check("shared role reset", 32'(sharedIsBackplane), 0);
    bus(1'b1, C, 8'hff);
    rd_check("control rw", C, 8'hbf);
    check("contrast", 32'(con), 32'hf);
    bus(1'b1, K, 8'hff);
    rd_check("clock rw", K, 8'h7f);
    bus(1'b1, 7'h50, 8'hff);
    rd_check("unmapped", 7'h50, 8'h00);
    for (int k = 0; k < lsd_pkg::LSD_SEG_REGS; k++)
      bus(1'b1, S + 7'(k), 8'h5a ^ 8'(k));
    for (int k = 0; k < lsd_pkg::LSD_SEG_REGS; k++)
      rd_check("segment", S + 7'(k), (8'h5a ^ 8'(k)) & ((k == 13) ?
        lsd_pkg::LSD_SEG_LAST_MASK : 8'hff));
    for (int s = 0; s < 3; s++)
    begin
      bus(1'b1, K, 8'h60 | 8'(s));
      bus(1'b1, C, 8'h80);
      p = 0;
      wait_lvl(1'b0, p);
      wait_lvl(1'b1, p);
      p = 0;
      wait_lvl(1'b0, p);
      wait_lvl(1'b1, p);
      check("base period", p, 512 << s);
    end
    bus(1'b1, K, 8'h67);
    repeat (4) @(posedge clock);
    check("reserved base", 32'(ladderConnect), 0);
    bus(1'b1, K, 8'h78);
    repeat (4) @(posedge clock);
    check("reserved duty", 32'(ladderConnect), 0);
    bus(1'b1, K, 8'h60);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, C, lt[i]);
      repeat (4) @(posedge clock);
      check("ladder current", 32'(ladderHighCurrent), 32'(!lt[i][4]));
    end
    for (int d = 0; d < 3; d++)
    begin
      bus(1'b1, K, 8'(d << 5));
      repeat (600) @(posedge clock);
      c = 0;
      for (int t = 0; t < 1024; t++)
      begin
        @(posedge clock);
        if (ladderHighCurrent === 1'b1)
          c++;
      end
      check("fast charge", c, 1024 >> (4 + d));
    end
    for (int d = 0; d < 3; d++)
    begin
      ph = (d == 0) ? 1 : d + 2;
      bus(1'b1, S, 8'h10);
      bus(1'b1, K, 8'(d << 3));
      bus(1'b1, C, 8'h80);
      repeat (3 * 512 * ph + 64) @(posedge clock);
      check("frame length", 32'(frameLen), 512 * ph);
      check("shared role", 32'(sharedIsBackplane), d == 2);
      check("segment on", 32'(litSeen), 1);
      bus(1'b1, S, 8'h00);
      repeat (3 * 512 * ph + 64) @(posedge clock);
      check("segment off", 32'(litSeen), 0);
    end
    for (int k = 0; k < 3; k++)
    begin
      // Enabling from off opens a charge window of ratio/128 ref edges;
      // the free reference phase costs a few clocks either way
      bus(1'b1, C, 8'h00);
      bus(1'b1, K, 8'h44 | 8'(k));
      bus(1'b1, C, 8'hb0);
      c = 0;
      repeat (4 * (128 << k) + 64)
      begin
        @(posedge clock);
        if (ladderHighCurrent === 1'b1)
          c++;
      end
      check("wide ratio", 32'(c > (512 << k) - 8 &&
        c < (512 << k) + 8), 1);
    end
    bus(1'b1, C, 8'h00);
    repeat (4) @(posedge clock);
    check("off pins", {|bp, |fp, |shp, ladderConnect, wbc}, 0);
    report_and_stop();
  end
endmodule
bind lsd_segment_driver lsd_segment_driver_props u_props (.*);
`default_nettype wire
